// >>> design/chs_host.sv
// Purpose: Host controller driving a removable flash card socket in card and disk modes
// Assumes: Mode inputs change only while the controller is idle; card pins are asynchronous
// Notes: Read data is taken from synchronised pins late in the strobe, so strobes last three cycles or more
// Contract
// - Acknowledge asserted: selects negated, sixteen bit width
// - Card modes: drive strap tied A25 or ground
// - Write strobe negated before entering Ultra DMA
// - Ground mode select for disk mode
// - Acknowledge only answering request, else high
`timescale 1ns/10ps
module chs_host
	import chs_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Mode configuration
	input wire logic i_ata_mode,
	input wire logic i_io_mode,
	input wire logic i_host8,
	input wire logic i_ata_slave,
	input wire logic i_socket_a25,
	// User request
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic [3:0] i_req_op,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic i_req_word,
	input wire logic i_req_ctl,
	input wire logic [DATA_W-1:0] i_req_wdata,
	input wire logic i_udma_stop,
	// User answer
	output logic o_rsp_valid,
	output logic o_rsp_err,
	output logic [DATA_W-1:0] o_rsp_rdata,
	// Socket control pins
	output logic o_low_card_enable_n,
	output logic o_high_card_enable_n,
	output logic o_address_bit_zero,
	output logic [ADDR_W-1:1] o_addr_hi,
	output logic o_task_file_select_n,
	output logic o_control_block_select_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_io_read_n,
	output logic o_io_write_strobe_n,
	output logic o_reg_n,
	output logic o_dmack_n,
	output logic o_disk_mode_select,
	output logic o_drive_select_strap_o,
	output logic o_drive_select_strap_oe,
	// Socket data bus and request
	input wire logic [DATA_W-1:0] i_data,
	output logic [DATA_W-1:0] o_data,
	output logic o_data_oe,
	input wire logic i_dmarq
);
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_SETUP, ST_STROBE, ST_HOLD, ST_UDMA, ST_STOP} chs_state_t;

	chs_state_t state_ff, nxt_state; // Cycle sequencer
	logic [CNT_W-1:0] cnt_ff, nxt_cnt; // Phase countdown
	chs_op_t op_ff, nxt_op; // Latched request code
	chs_pins_t pins_ff, nxt_pins; // Registered socket pins
	logic rsp_valid_ff, nxt_rsp_valid; // Answer pulse
	logic rsp_err_ff, nxt_rsp_err; // Refusal flag with the pulse
	logic [DATA_W-1:0] rdata_ff, nxt_rdata; // Captured read data
	logic strap_o_ff, nxt_strap_o; // Drive-select level
	logic strap_oe_ff, nxt_strap_oe; // Drive-select enable
	logic mode_sel_ff, nxt_mode_sel; // Mode-select pin level
	logic [DATA_W-1:0] data_s1_ff, data_s2_ff; // Data pin synchroniser
	logic dmarq_s1_ff, dmarq_s2_ff; // Request pin synchroniser
	logic legal; // Request may run in the current mode
	logic is_read; // Request reads the card
	chs_op_t req_op; // Request code as enum

	chs_lane_if lane();

	chs_lane_steer u_steer (
		.lane(lane.steer)
	);

	assign req_op = chs_op_t'(i_req_op);
	assign lane.host8 = i_host8;
	// Lanes follow the request while idle, then the driven pins, so extraction sees the bus late in the strobe
	assign lane.word = (state_ff == ST_IDLE) ? i_req_word : !(pins_ff.low_card_enable_n | pins_ff.high_card_enable_n);
	assign lane.odd = (state_ff == ST_IDLE) ? i_req_addr[0] : pins_ff.address_bit_zero;
	assign lane.wdata = i_req_wdata;
	assign lane.pin_rdata = data_s2_ff;

	// Reads: these ops capture data instead of driving it
	function automatic logic op_reads(input chs_op_t op);
		return op inside {CHS_OP_MEM_RD, CHS_OP_ATTR_RD, CHS_OP_IO_RD, CHS_OP_DMA_RD};
	endfunction

	// Which strobe an op uses, applied to a pin set
	function automatic chs_pins_t with_strobe(input chs_pins_t p, input chs_op_t op, input logic lvl_n);
		chs_pins_t r;
		r = p;
		unique case (op)
			CHS_OP_MEM_RD, CHS_OP_ATTR_RD: r.oe_n = lvl_n;
			CHS_OP_MEM_WR, CHS_OP_ATTR_WR: r.we_n = lvl_n;
			CHS_OP_IO_RD, CHS_OP_DMA_RD: r.io_read_n = lvl_n;
			CHS_OP_IO_WR, CHS_OP_DMA_WR: r.io_write_strobe_n = lvl_n;
			default: r = p;
		endcase
		return r;
	endfunction

	// Legality of a request against the mode straps
	always_comb
	begin
		is_read = op_reads(req_op);
		unique case (req_op)
			CHS_OP_MEM_RD, CHS_OP_MEM_WR: legal = !i_ata_mode && !i_io_mode && !lane.illegal;
			CHS_OP_ATTR_RD, CHS_OP_ATTR_WR: legal = !i_ata_mode && !lane.illegal;
			CHS_OP_IO_RD, CHS_OP_IO_WR: legal = i_ata_mode || (i_io_mode && !lane.illegal);
			CHS_OP_DMA_RD, CHS_OP_DMA_WR, CHS_OP_UDMA: legal = i_ata_mode;
			default: legal = 1'b0;
		endcase
	end

	// Two flip-flops on every pin input before use
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			data_s1_ff <= DOUT_RST;
			data_s2_ff <= DOUT_RST;
			dmarq_s1_ff <= 1'b0;
			dmarq_s2_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			data_s1_ff <= i_data;
			data_s2_ff <= data_s1_ff;
			dmarq_s1_ff <= i_dmarq;
			dmarq_s2_ff <= dmarq_s1_ff;
		end
	end

	// Sequencer next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_op = op_ff;
		nxt_pins = pins_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_err = rsp_err_ff;
		nxt_rdata = rdata_ff;
		// Straps follow the mode only while idle, so a cycle never sees them move
		nxt_strap_o = strap_o_ff;
		nxt_strap_oe = strap_oe_ff;
		nxt_mode_sel = mode_sel_ff;
		unique case (state_ff)
			ST_IDLE:
			begin
				nxt_mode_sel = !i_ata_mode;
				nxt_strap_o = i_ata_mode ? 1'b0 : i_socket_a25;
				nxt_strap_oe = i_ata_mode ? !i_ata_slave : 1'b1;
				nxt_pins = PINS_IDLE;
				if (i_req_valid && !legal)
				begin
					// Refused at once, pins untouched
					nxt_rsp_valid = 1'b1;
					nxt_rsp_err = 1'b1;
				end
				else if (i_req_valid)
				begin
					nxt_op = req_op;
					nxt_rsp_err = 1'b0;
					nxt_pins.addr_hi = i_req_addr[ADDR_W-1:1];
					nxt_pins.doe = !is_read;
					if (i_ata_mode)
					begin
						nxt_pins.address_bit_zero = i_req_addr[0];
						nxt_pins.dout = i_req_wdata;
						if (req_op inside {CHS_OP_IO_RD, CHS_OP_IO_WR})
						begin
							nxt_pins.task_file_select_n = i_req_ctl;
							nxt_pins.control_block_select_n = !i_req_ctl;
						end
					end
					else
					begin
						nxt_pins.low_card_enable_n = lane.ce_low_n;
						nxt_pins.high_card_enable_n = lane.ce_high_n;
						nxt_pins.address_bit_zero = lane.a0;
						nxt_pins.dout = lane.pin_wdata;
						nxt_pins.reg_n = !(req_op inside {CHS_OP_ATTR_RD, CHS_OP_ATTR_WR, CHS_OP_IO_RD, CHS_OP_IO_WR});
					end
					if (req_op inside {CHS_OP_DMA_RD, CHS_OP_DMA_WR, CHS_OP_UDMA})
					begin
						// Acknowledge waits for the request; bus held off until then
						nxt_pins.doe = 1'b0;
						nxt_state = ST_WAIT;
					end
					else
					begin
						nxt_cnt = CNT_W'(SETUP_CYC - 1);
						nxt_state = ST_SETUP;
					end
				end
			end
			ST_WAIT:
			begin
				if (dmarq_s2_ff)
				begin
					nxt_pins.dmack_n = 1'b0;
					nxt_pins.task_file_select_n = 1'b1;
					nxt_pins.control_block_select_n = 1'b1;
					if (op_ff == CHS_OP_UDMA)
					begin
						// Write strobe was negated in idle; now stop is held negated
						nxt_pins.io_write_strobe_n = 1'b0;
						nxt_state = ST_UDMA;
					end
					else
					begin
						nxt_pins.doe = (op_ff == CHS_OP_DMA_WR);
						nxt_cnt = CNT_W'(SETUP_CYC - 1);
						nxt_state = ST_SETUP;
					end
				end
			end
			ST_SETUP:
			begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == '0)
				begin
					nxt_pins = with_strobe(pins_ff, op_ff, 1'b0);
					nxt_cnt = CNT_W'(STROBE_CYC - 1);
					nxt_state = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == '0)
				begin
					// Synchroniser lags two cycles, still inside the strobe
					if (op_reads(op_ff))
					begin
						// Card modes pick the lane from the enables held on the pins
						nxt_rdata = (op_ff == CHS_OP_DMA_RD || i_ata_mode) ? data_s2_ff : lane.rdata;
					end
					// Data stays driven past the rising edge so the card takes it there
					nxt_pins = with_strobe(pins_ff, op_ff, 1'b1);
					nxt_cnt = CNT_W'(HOLD_CYC - 1);
					nxt_state = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == '0)
				begin
					nxt_pins = PINS_IDLE;
					nxt_rsp_valid = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_UDMA:
			begin
				if (i_udma_stop || !dmarq_s2_ff)
				begin
					nxt_pins.io_write_strobe_n = 1'b1;
					nxt_cnt = CNT_W'(STOP_HOLD_CYC - 1);
					nxt_state = ST_STOP;
				end
			end
			ST_STOP:
			begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == '0)
				begin
					nxt_pins = PINS_IDLE;
					nxt_rsp_valid = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
			op_ff <= CHS_OP_MEM_RD;
			pins_ff <= PINS_IDLE;
			rsp_valid_ff <= 1'b0;
			rsp_err_ff <= 1'b0;
			rdata_ff <= DOUT_RST;
			strap_o_ff <= 1'b0;
			strap_oe_ff <= 1'b1;
			mode_sel_ff <= 1'b1;
		end
		else if (i_ce)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			op_ff <= nxt_op;
			pins_ff <= nxt_pins;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_err_ff <= nxt_rsp_err;
			rdata_ff <= nxt_rdata;
			strap_o_ff <= nxt_strap_o;
			strap_oe_ff <= nxt_strap_oe;
			mode_sel_ff <= nxt_mode_sel;
		end
	end

	// Ready is combinational; held low while the clock enable is low
	assign o_req_ready = (state_ff == ST_IDLE) && i_ce;
	assign o_rsp_valid = rsp_valid_ff && i_ce;
	assign o_rsp_err = rsp_err_ff;
	assign o_rsp_rdata = rdata_ff;
	assign o_low_card_enable_n = pins_ff.low_card_enable_n;
	assign o_high_card_enable_n = pins_ff.high_card_enable_n;
	assign o_address_bit_zero = pins_ff.address_bit_zero;
	assign o_addr_hi = pins_ff.addr_hi;
	assign o_task_file_select_n = pins_ff.task_file_select_n;
	assign o_control_block_select_n = pins_ff.control_block_select_n;
	assign o_oe_n = pins_ff.oe_n;
	assign o_we_n = pins_ff.we_n;
	assign o_io_read_n = pins_ff.io_read_n;
	assign o_io_write_strobe_n = pins_ff.io_write_strobe_n;
	assign o_reg_n = pins_ff.reg_n;
	assign o_dmack_n = pins_ff.dmack_n;
	assign o_data = pins_ff.dout;
	assign o_data_oe = pins_ff.doe;
	assign o_disk_mode_select = mode_sel_ff;
	assign o_drive_select_strap_o = strap_o_ff;
	assign o_drive_select_strap_oe = strap_oe_ff;
endmodule

// >>> design/chs_lane_if.sv
// Purpose: Byte-lane steering request and answer between controller and steering logic
// Assumes: Purely combinational exchange on one clock
// Notes: Controller drives the request, steering logic drives the answer
`timescale 1ns/10ps
interface chs_lane_if;
	import chs_pkg::*;
	logic host8; // Host reaches the card over the low data lines only
	logic word; // Full 16 bit access requested
	logic odd; // Byte address is odd
	logic [DATA_W-1:0] wdata; // User write data, byte in low bits
	logic [DATA_W-1:0] pin_rdata; // Synchronised data pins
	logic ce_low_n; // Low card enable level for the access
	logic ce_high_n; // High card enable level for the access
	logic a0; // Address bit zero level for the access
	logic [DATA_W-1:0] pin_wdata; // Write data placed on its lane
	logic [DATA_W-1:0] rdata; // Read data taken from its lane
	logic illegal; // Combination the socket cannot carry

	modport ctrl (output host8, word, odd, wdata, pin_rdata,
		input ce_low_n, ce_high_n, a0, pin_wdata, rdata, illegal);
	modport steer (input host8, word, odd, wdata, pin_rdata,
		output ce_low_n, ce_high_n, a0, pin_wdata, rdata, illegal);
endinterface

// >>> design/chs_lane_steer.sv
// Purpose: Card enable and byte-lane steering for word and byte accesses
// Assumes: Used only for card-socket cycles; disk mode ignores the enables
// Notes: Word access from an eight bit host is flagged, not split
`timescale 1ns/10ps
module chs_lane_steer
	import chs_pkg::*;
(
	// Lane request and answer
	chs_lane_if.steer lane
);
	// Enables, lane placement and extraction from width, host width and byte address
	always_comb
	begin
		lane.illegal = 1'b0;
		lane.a0 = 1'b0;
		lane.ce_low_n = 1'b0;
		lane.ce_high_n = 1'b0;
		lane.pin_wdata = lane.wdata;
		lane.rdata = lane.pin_rdata;
		if (lane.word)
		begin
			// Both enables low, even address
			lane.illegal = lane.host8;
		end
		else if (!lane.odd)
		begin
			// Even byte always on the low enable and low lines
			lane.ce_high_n = 1'b1;
			lane.rdata = {8'h00, lane.pin_rdata[7:0]};
		end
		else if (lane.host8)
		begin
			// Odd byte through the low enable, steered by address bit zero
			lane.ce_high_n = 1'b1;
			lane.a0 = 1'b1;
			lane.rdata = {8'h00, lane.pin_rdata[7:0]};
		end
		else
		begin
			// Odd byte through the high enable on the high lines
			lane.ce_low_n = 1'b1;
			lane.a0 = 1'b1;
			lane.pin_wdata = {lane.wdata[7:0], 8'h00};
			lane.rdata = {8'h00, lane.pin_rdata[15:8]};
		end
	end
endmodule

// >>> design/chs_pkg.sv
// Purpose: Shared constants and types for the card host select and strobe controller
// Assumes: 10 MHz i_clk; all card strobes are active low at the socket
// Notes: Timing figures are plain defaults, sized for a slow card cycle
package chs_pkg;
	// Clock period of i_clk
	localparam int CLK_PERIOD_NS = 100;
	// Address setup before a strobe, least time
	localparam int SETUP_NS = 70;
	// Strobe low width, least time; must give three or more cycles for read capture
	localparam int STROBE_NS = 300;
	// Address and data hold after the strobe rises, least time
	localparam int HOLD_NS = 30;
	// Stop held asserted before the acknowledge is released, least time
	localparam int STOP_HOLD_NS = 200;

	// Least time to cycles, rounded up, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
	localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
	localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
	localparam int STOP_HOLD_CYC = ns_to_cyc(STOP_HOLD_NS);
	// Phase counter width
	localparam int CNT_W = 4;
	// Card address width, bit 0 carried separately
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	// Reset value of the data bus output
	localparam logic [DATA_W-1:0] DOUT_RST = 16'h0000;

	// Host request codes
	typedef enum logic [3:0] {
		CHS_OP_MEM_RD,
		CHS_OP_MEM_WR,
		CHS_OP_ATTR_RD,
		CHS_OP_ATTR_WR,
		CHS_OP_IO_RD,
		CHS_OP_IO_WR,
		CHS_OP_DMA_RD,
		CHS_OP_DMA_WR,
		CHS_OP_UDMA
	} chs_op_t;

	// Socket pins driven by the host, all from flip-flops
	typedef struct packed {
		logic low_card_enable_n;
		logic high_card_enable_n;
		logic address_bit_zero;
		logic [ADDR_W-1:1] addr_hi;
		logic task_file_select_n;
		logic control_block_select_n;
		logic oe_n;
		logic we_n;
		logic io_read_n;
		logic io_write_strobe_n;
		logic reg_n;
		logic dmack_n;
		logic [DATA_W-1:0] dout;
		logic doe;
	} chs_pins_t;

	// Idle pin state: everything negated, bus released
	localparam chs_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b0, '0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b1, DOUT_RST, 1'b0};
endpackage

// >>> verif/chs_card_model.sv
// Purpose: Behavioural card at the socket, card and disk modes
// Assumes: Pins move on host clock edges; the bench resolves the data bus
// Notes: Small word store per space; undriven lines toggle each cycle
`timescale 1ns/10ps
module chs_card_model (
	// Pattern clock and socket pins
	input wire logic i_clk,
	input wire logic i_ce_l_n,
	input wire logic i_ce_h_n,
	input wire logic i_a0,
	input wire logic [2:1] i_a,
	input wire logic i_tf_n,
	input wire logic i_cb_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_reg_n,
	input wire logic i_ack_n,
	input wire logic i_msel,
	input wire logic i_strap,
	input wire logic [15:0] i_bus,
	// Bench controls
	input wire logic i_io_cfg,
	input wire logic i_want,
	// Card side results
	output logic [15:0] o_data,
	output logic o_dmarq,
	output logic o_master,
	output logic o_stopped
);
	logic [15:0] mem [0:31]; // Space in top index bits
	logic [15:0] junk = 16'h3C5A; // Released bus pattern
	logic udma = 1'b0; // Burst entered with stop negated
	logic dk_q = 1'b1; // Acknowledge last cycle
	logic stop_seen = 1'b0;
	logic ata, full, rd;
	logic [2:0] rsp;
	logic [15:0] w;
	assign ata = !i_msel;
	assign o_master = ata && !i_strap;
	assign full = ata || !i_ack_n || !(i_ce_l_n | i_ce_h_n);
	assign o_dmarq = i_want && !stop_seen;
	assign o_stopped = stop_seen;
	// Space of a cycle, 7 when not selected
	function automatic logic [2:0] space(input logic io);
		if (!i_ack_n)
			return 3'h5;
		if (ata)
			return !i_tf_n ? 3'h3 : (!i_cb_n ? 3'h4 : 3'h7);
		if (i_ce_l_n && i_ce_h_n)
			return 3'h7;
		if (io)
			return 3'h2;
		return !i_reg_n ? 3'h1 : (i_io_cfg ? 3'h7 : 3'h0);
	endfunction
	// Read drive, lanes steered by the enables
	always_comb
	begin
		rsp = space(!i_rd_n);
		rd = (rsp != 3'h7) && (!i_rd_n || (!ata && i_ack_n && !i_oe_n));
		w = mem[{rsp, i_a}];
		o_data = junk;
		if (rd && (full || !i_ce_l_n))
			o_data[7:0] = (!full && i_a0) ? w[15:8] : w[7:0];
		if (rd && (full || !i_ce_h_n))
			o_data[15:8] = w[15:8];
	end
	// Capture at the trailing strobe edge
	task automatic cap(input logic [2:0] s);
		logic [4:0] ix;
		ix = {s, i_a};
		if (s == 3'h7 || $isunknown(s))
			return;
		if (full)
			mem[ix] = i_bus;
		else if (!i_ce_l_n)
			if (i_a0)
				mem[ix][15:8] = i_bus[7:0];
			else
				mem[ix][7:0] = i_bus[7:0];
		if (!full && !i_ce_h_n)
			mem[ix][15:8] = i_bus[15:8];
	endtask
	always @(posedge i_wr_n)
		if (!udma)
			cap(space(1'b1));
	always @(posedge i_we_n)
		cap(space(1'b0));
	// Burst entry and stop tracking
	always @(posedge i_clk)
	begin
		junk <= ~junk;
		dk_q <= i_ack_n;
		if (dk_q && !i_ack_n)
			udma <= !i_wr_n;
		else if (i_ack_n)
			udma <= 1'b0;
		if (udma && !i_ack_n && i_wr_n)
			stop_seen <= 1'b1;
		else if (!i_want)
			stop_seen <= 1'b0;
	end
endmodule

// >>> verif/chs_host_monitor.sv
// Purpose: Concurrent checks on the host socket pins
// Assumes: One clock domain, reset asynchronous and active high
// Notes: Sees top ports only; the bind sits after the module
`timescale 1ns/10ps
module chs_host_monitor (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Watched inputs
	input wire logic i_ata_mode,
	input wire logic i_ata_slave,
	input wire logic i_socket_a25,
	input wire logic i_dmarq,
	// Watched outputs
	input wire logic o_req_ready,
	input wire logic o_rsp_valid,
	input wire logic o_rsp_err,
	input wire logic o_low_card_enable_n,
	input wire logic o_high_card_enable_n,
	input wire logic o_task_file_select_n,
	input wire logic o_control_block_select_n,
	input wire logic o_io_write_strobe_n,
	input wire logic o_dmack_n,
	input wire logic o_disk_mode_select,
	input wire logic o_drive_select_strap_o,
	input wire logic o_drive_select_strap_oe
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Acknowledge owns the bus, no register selects
	a_dmack_sel_neg: assert property (!o_dmack_n |-> o_task_file_select_n && o_control_block_select_n)
		else $error("select active under acknowledge");
	// Disk transfers are whole words, card enables unused
	a_dmack_ce_neg: assert property (!o_dmack_n |-> o_low_card_enable_n && o_high_card_enable_n)
		else $error("card enable active under acknowledge");
	// Card modes: strap pin follows the socket line while idle
	a_strap_card_a25: assert property (o_req_ready && !i_ata_mode |=> o_drive_select_strap_oe && o_drive_select_strap_o == $past(i_socket_a25))
		else $error("strap pin not tied to socket line");
	// Disk mode needs the mode pin grounded
	a_mode_ground: assert property (o_req_ready && i_ata_mode |=> !o_disk_mode_select && !o_drive_select_strap_o)
		else $error("mode pin not grounded in disk mode");
	// Master grounds the strap, slave leaves it open
	a_strap_disk_role: assert property (o_req_ready && i_ata_mode |=> o_drive_select_strap_oe == !$past(i_ata_slave))
		else $error("strap role wrong");
	// Write strobe negated before any acknowledge
	a_stop_negated_entry: assert property ($fell(o_dmack_n) |-> $past(o_io_write_strobe_n))
		else $error("write strobe active at acknowledge");
	// Acknowledge only answers a request
	a_dmack_after_req: assert property ($fell(o_dmack_n) |-> $past(i_dmarq))
		else $error("acknowledge without request");
	// Acknowledge released only as the transfer ends
	a_dmack_release_rsp: assert property ($rose(o_dmack_n) |-> o_rsp_valid && !o_rsp_err)
		else $error("acknowledge released mid transfer");
	c_refused: cover property (o_rsp_valid && o_rsp_err);
	c_dma: cover property ($fell(o_dmack_n));
	c_word: cover property (!o_low_card_enable_n && !o_high_card_enable_n);
endmodule

bind chs_host chs_host_monitor u_mon (.*);

// >>> verif/chs_host_tb.sv
// Purpose: Self-checking bench for the card host controller
// Assumes: Card model on the socket; clock enable held high
// Notes: Driver queues expected answers, a watcher checks them
`timescale 1ns/10ps
module chs_host_tb;
	import chs_pkg::*;
	logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_ata_mode = 1'b0, i_io_mode = 1'b0, i_host8 = 1'b0;
	logic i_ata_slave = 1'b0, i_socket_a25 = 1'b0, i_req_valid = 1'b0, i_req_word = 1'b0, i_req_ctl = 1'b0;
	logic i_udma_stop = 1'b0, i_dmarq, dma_want = 1'b0, strap_pin, master, stopped;
	logic [3:0] i_req_op = 4'h0;
	logic [ADDR_W-1:0] i_req_addr = '0;
	logic [DATA_W-1:0] i_req_wdata = '0, i_data, o_data, o_rsp_rdata, card_data;
	logic o_req_ready, o_rsp_valid, o_rsp_err, o_low_card_enable_n, o_high_card_enable_n, o_address_bit_zero;
	logic o_task_file_select_n, o_control_block_select_n, o_oe_n, o_we_n, o_io_read_n, o_io_write_strobe_n;
	logic o_reg_n, o_dmack_n, o_disk_mode_select, o_drive_select_strap_o, o_drive_select_strap_oe, o_data_oe;
	logic [ADDR_W-1:1] o_addr_hi;
	logic [17:0] exp_q [$]; // Check flag, error, data
	logic [17:0] e;
	logic [31:0] rnd = 32'h42E6;
	int num_errors = 0, checks_done = 0;
	// Bus and strap wires; strap line is pulled up
	assign i_data = o_data_oe ? o_data : card_data;
	assign strap_pin = o_drive_select_strap_oe ? o_drive_select_strap_o : 1'b1;
	chs_host DUT (.*);
	chs_card_model u_card (.i_clk(i_clk), .i_ce_l_n(o_low_card_enable_n), .i_ce_h_n(o_high_card_enable_n),
		.i_a0(o_address_bit_zero), .i_a(o_addr_hi[2:1]), .i_tf_n(o_task_file_select_n),
		.i_cb_n(o_control_block_select_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_rd_n(o_io_read_n),
		.i_wr_n(o_io_write_strobe_n), .i_reg_n(o_reg_n), .i_ack_n(o_dmack_n), .i_msel(o_disk_mode_select),
		.i_strap(strap_pin), .i_bus(i_data), .i_io_cfg(i_io_mode), .i_want(dma_want), .o_data(card_data),
		.o_dmarq(i_dmarq), .o_master(master), .o_stopped(stopped));
	initial
	begin
		forever #50 i_clk = ~i_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One request, taken at the next edge
	task automatic issue(input logic [3:0] op, input logic [10:0] a, input logic wd, input logic [15:0] wv,
		input logic [17:0] x);
		{i_req_op, i_req_addr, i_req_word, i_req_wdata, i_req_valid} = {op, a, wd, wv, 1'b1};
		exp_q.push_back(x);
		@(posedge i_clk);
		#10 i_req_valid = 1'b0;
	endtask
	// Bounded wait for the answer, then one more edge
	task automatic wait_rsp;
		int n;
		n = 0;
		while (o_rsp_valid !== 1'b1 && n < 200)
		begin
			@(negedge i_clk);
			n++;
		end
		if (n == 200)
			num_errors++;
		@(posedge i_clk);
		#10;
	endtask
	task automatic acc(input logic [3:0] op, input logic [10:0] a, input logic wd, input logic [15:0] wv,
		input logic [17:0] x);
		issue(op, a, wd, wv, x);
		wait_rsp;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Oldest note against each answer
	always @(negedge i_clk)
		if (o_rsp_valid === 1'b1)
		begin
			e = exp_q.pop_front();
			check("rsp_err", {15'h0, o_rsp_err}, {15'h0, e[16]});
			if (e[17])
				check("rsp_rdata", o_rsp_rdata, e[15:0]);
		end
	// Watchdog well beyond the expected run
	initial
	begin
		#2000000;
		num_errors++;
		stop_test;
	end
	initial
	begin
		repeat (20) @(posedge i_clk);
		#10 i_rst = 1'b0;
		// Sixteen bit host: word, even and odd bytes
		acc(4'h1, 11'h004, 1'b1, 16'hBEEF, 18'h0);
		acc(4'h1, 11'h008, 1'b0, 16'h0011, 18'h0);
		acc(4'h1, 11'h009, 1'b0, 16'h0022, 18'h0);
		acc(4'h0, 11'h008, 1'b1, 16'h0, {2'b10, 16'h2211});
		acc(4'h0, 11'h005, 1'b0, 16'h0, {2'b10, 16'h00BE});
		acc(4'h0, 11'h004, 1'b0, 16'h0, {2'b10, 16'h00EF});
		acc(4'h4, 11'h004, 1'b1, 16'h0, 18'h10000);
		acc(4'h7, 11'h004, 1'b1, 16'h0, 18'h10000);
		$display("test lanes16 done");
		// Eight bit host: odd bytes on low lines, word refused
		i_host8 = 1'b1;
		acc(4'h1, 11'h00B, 1'b0, 16'h005A, 18'h0);
		acc(4'h0, 11'h00B, 1'b0, 16'h0, {2'b10, 16'h005A});
		acc(4'h0, 11'h005, 1'b0, 16'h0, {2'b10, 16'h00BE});
		acc(4'h0, 11'h004, 1'b1, 16'h0, 18'h10000);
		i_host8 = 1'b0;
		acc(4'h3, 11'h002, 1'b0, 16'h0077, 18'h0);
		acc(4'h2, 11'h002, 1'b0, 16'h0, {2'b10, 16'h0077});
		$display("test lanes8 done");
		// I/O card: write strobe capture, output enable for structure only
		{i_io_mode, i_socket_a25} = 2'b11;
		acc(4'h5, 11'h006, 1'b1, 16'hC3A5, 18'h0);
		acc(4'h4, 11'h006, 1'b1, 16'h0, {2'b10, 16'hC3A5});
		acc(4'h2, 11'h002, 1'b0, 16'h0, {2'b10, 16'h0077});
		acc(4'h0, 11'h004, 1'b1, 16'h0, 18'h10000);
		i_io_mode = 1'b0;
		$display("test io done");
		// Disk mode: strap roles, both selects, refused codes
		i_ata_mode = 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			i_ata_slave = s[0];
			repeat (2) @(posedge i_clk);
			#10 check("master", {15'h0, master}, {15'h0, !s[0]});
		end
		repeat (37) rnd = lfsr(rnd);
		acc(4'h5, 11'h004, 1'b1, rnd[15:0], 18'h0);
		i_req_ctl = 1'b1;
		acc(4'h5, 11'h004, 1'b1, rnd[31:16], 18'h0);
		acc(4'h4, 11'h004, 1'b1, 16'h0, {2'b10, rnd[31:16]});
		i_req_ctl = 1'b0;
		acc(4'h4, 11'h004, 1'b1, 16'h0, {2'b10, rnd[15:0]});
		for (int k = 0; k < 16; k++)
			if (k < 4 || k > 8)
				acc(k[3:0], 11'h0, 1'b1, 16'h0, 18'h10000);
		$display("test disk done");
		// Multiword transfer out and back
		dma_want = 1'b1;
		rnd = lfsr(rnd);
		acc(4'h7, 11'h0, 1'b1, rnd[15:0], 18'h0);
		acc(4'h6, 11'h0, 1'b1, 16'h0, {2'b10, rnd[15:0]});
		// Burst entered with stop negated, then stopped
		issue(4'h8, 11'h0, 1'b1, 16'h0, 18'h0);
		repeat (6) @(posedge i_clk);
		#10 i_udma_stop = 1'b1;
		wait_rsp;
		check("stopped", {15'h0, stopped}, 16'h0001);
		{i_udma_stop, dma_want} = 2'b00;
		$display("test dma done");
		stop_test;
	end
endmodule
